// ### design/ombc_pkg.sv
// Shared constants and decode functions for the on-chip memory controller.
// Assumes big-endian bit numbering on every bus: bit 0 is the most significant.
package ombc_pkg;

   // ==========================================================
   // Widths
   localparam int DCR_AW   = 10;
   localparam int DCR_DW   = 32;
   localparam int REG_W    = 8;
   localparam int DATA_AW  = 22;
   localparam int INST_AW  = 21;

   // ==========================================================
   // Register offsets (two low address bits of the register bus)
   localparam logic [1:0] OFS_INST_WR_ADDR = 2'h0;
   localparam logic [1:0] OFS_INST_FILL    = 2'h1;
   localparam logic [1:0] OFS_RANGE        = 2'h2;
   localparam logic [1:0] OFS_CTRL         = 2'h3;

   // ==========================================================
   // Control register fields (big-endian positions within [0:7])
   localparam int CTRL_EN_BIT   = 0;
   localparam int CTRL_FLAG_BIT = 2;

   // ==========================================================
   // Values held while reset is asserted (control and range until the tie inputs load), and the write address step
   localparam logic [0:7]  CTRL_RESET    = 8'h00;
   localparam logic [0:7]  RANGE_RESET   = 8'h00;
   localparam logic [0:20] WR_ADDR_RESET = 21'h000000;
   localparam logic [0:31] FILL_RESET    = 32'h00000000;
   localparam logic [0:20] WR_ADDR_STEP  = 21'h000001;

   // ==========================================================
   // Decoding functions
   // Register bus select: upper eight address bits match the tie base
   function automatic logic dcr_sel(input logic [0:9] abus, input logic [0:7] base);
      return abus[0:7] == base;
   endfunction

   // Register offset within a side
   function automatic logic [1:0] dcr_ofs(input logic [0:9] abus);
      return abus[8:9];
   endfunction

   // Region hit: decoder enabled and top address byte equals range compare
   function automatic logic region_hit(input logic [0:7] top, input logic [0:7] rng,
                                       input logic [0:7] ctrl);
      return ctrl[CTRL_EN_BIT] && (top == rng);
   endfunction

endpackage

// ### design/ombc_dcr_if.sv
// Register bus link between the top module and the data-side controller.
// Assumes the top module drives requests and the data side answers.
`timescale 1ns/10ps
interface ombc_dcr_if;
   logic        read;
   logic        write;
   logic [0:9]  abus;
   logic [0:31] wdata;
   logic [0:31] rdata;
   logic        ack;
   logic        sel;

   modport master (output read, output write, output abus, output wdata,
                   input rdata, input ack, input sel);
   modport slave  (input read, input write, input abus, input wdata,
                   output rdata, output ack, output sel);
endinterface

// ### design/ombc_data_side.sv
// Data-side controller: load/store path to data memory plus its two registers.
// Assumes requests and register bus come from logic on sys_clk; ties are static.
`timescale 1ns/10ps
module ombc_data_side (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   ombc_dcr_if.slave        dcr,
   input  wire logic [0:7]  data_ctrl_default,
   input  wire logic [0:7]  data_range_default,
   input  wire logic [0:7]  data_reg_base_tie,
   input  wire logic        cpu_ld_req,
   input  wire logic [0:31] cpu_ld_addr,
   output logic             cpu_ld_ack,
   output logic [0:31]      cpu_ld_data,
   output logic             cpu_ld_valid,
   input  wire logic        cpu_st_req,
   input  wire logic [0:31] cpu_st_addr,
   input  wire logic [0:31] cpu_st_data,
   input  wire logic [0:3]  cpu_st_be,
   output logic             cpu_st_ack,
   output logic [8:29]      data_addr_bus,
   output logic [0:31]      data_wr_bus,
   output logic [0:3]       data_byte_we,
   output logic             data_mem_en,
   input  wire logic [0:31] data_rd_bus,
   output logic             sw_flag_out
);

   // ==========================================================
   // Register file
   logic        init_q;
   logic [0:7]  ctrl_q;
   logic [0:7]  range_q;
   logic        ack_q;
   logic [0:31] rdata_q;
   logic        take;
   logic [1:0]  ofs;

   // Request taken once, on the first cycle it is seen
   assign dcr.sel = ombc_pkg::dcr_sel(dcr.abus, data_reg_base_tie);
   assign ofs     = ombc_pkg::dcr_ofs(dcr.abus);
   assign take    = (dcr.read || dcr.write) && dcr.sel && !ack_q;
   assign dcr.ack   = ack_q;
   assign dcr.rdata = rdata_q;

   // One-cycle flag that loads the tie defaults after reset release
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         init_q <= 1'b1;
      else
         init_q <= 1'b0;

   // Control register
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         ctrl_q <= ombc_pkg::CTRL_RESET;
      else if (init_q)
         ctrl_q <= data_ctrl_default;
      else if (take && dcr.write && ofs == ombc_pkg::OFS_CTRL)
         ctrl_q <= dcr.wdata[24:31];

   // Range compare register
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         range_q <= ombc_pkg::RANGE_RESET;
      else if (init_q)
         range_q <= data_range_default;
      else if (take && dcr.write && ofs == ombc_pkg::OFS_RANGE)
         range_q <= dcr.wdata[24:31];

   // Acknowledge follows the request one cycle later; read data captured at take
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         ack_q <= (dcr.read || dcr.write) && dcr.sel;
         if (take)
            case (ofs)
               ombc_pkg::OFS_RANGE: rdata_q <= {24'h000000, range_q};
               ombc_pkg::OFS_CTRL:  rdata_q <= {24'h000000, ctrl_q};
               default:             rdata_q <= 32'h00000000;
            endcase
      end

   // Software flag mirrored to the fabric
   assign sw_flag_out = ctrl_q[ombc_pkg::CTRL_FLAG_BIT];

   // ==========================================================
   // Load/store path
   logic ld_hit;
   logic st_hit;
   logic rd_p1_q;
   logic rd_p2_q;

   assign ld_hit     = ombc_pkg::region_hit(cpu_ld_addr[0:7], range_q, ctrl_q);
   assign st_hit     = ombc_pkg::region_hit(cpu_st_addr[0:7], range_q, ctrl_q);
   // Load wins when both contend; the store waits
   assign cpu_ld_ack = cpu_ld_req && ld_hit;
   assign cpu_st_ack = cpu_st_req && st_hit && !cpu_ld_ack;

   // Memory-side outputs launched from flops
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         data_addr_bus <= 22'h000000;
         data_wr_bus   <= 32'h00000000;
         data_byte_we  <= 4'h0;
         data_mem_en   <= 1'b0;
      end
      else
      begin
         data_mem_en  <= cpu_ld_ack || cpu_st_ack;
         data_byte_we <= cpu_st_ack ? cpu_st_be : 4'h0;
         if (cpu_ld_ack)
            data_addr_bus <= cpu_ld_addr[8:29];
         else if (cpu_st_ack)
         begin
            data_addr_bus <= cpu_st_addr[8:29];
            data_wr_bus   <= cpu_st_data;
         end
      end

   // Read pipeline: enable cycle, memory data cycle, then load data returned
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         rd_p1_q      <= 1'b0;
         rd_p2_q      <= 1'b0;
         cpu_ld_valid <= 1'b0;
         cpu_ld_data  <= 32'h00000000;
      end
      else
      begin
         rd_p1_q      <= cpu_ld_ack;
         rd_p2_q      <= rd_p1_q;
         cpu_ld_valid <= rd_p2_q;
         if (rd_p2_q)
            cpu_ld_data <= data_rd_bus;
      end

endmodule

// ### design/ombc_onchip_mem_ctrl.sv
// Top of the on-chip memory controller: instruction side, register bus
// loop shared with the fabric chain, and the data-side controller.
// Assumes one clock, sys_clk; the memory clocks are equal to it, and all
// processor, register bus and fabric signals are synchronous to it.
// Tie inputs are static once reset is released.
//
// Behaviour
// - Four byte write strobes, strobe 0 is bits 0-7
// - Data address is processor bits 8 to 29
// - Data memory enable on every read or write
// - Load served before a contending store
// - Flag output mirrors data control bit 2
// - Control and range registers load tie defaults after reset
// - Ten-bit register address, upper eight from tie
// - Instruction offsets: address, fill, range, control
// - Fetch address bits 8-28, 64-bit read data
// - Write address and data come from registers
// - Separate even and odd write enables
// - Read enable only on valid fetch cycles
// - Data and instruction sides fully independent
// - Register bus writes instruction words at initialisation
// - Each side claims its own 16MB region
// - Fourteen address bits give 64KB/128KB, all 16MB
// - Register loop multiplexed with fabric chain
// - Top address byte compared with range register
// - Write address increments after each fill
`timescale 1ns/10ps
module ombc_onchip_mem_ctrl (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Register bus from the processor
   input  wire logic        dcr_read,
   input  wire logic        dcr_write,
   input  wire logic [0:9]  dcr_abus,
   input  wire logic [0:31] dcr_wr_dbus,
   output logic [0:31]      dcr_rd_dbus,
   output logic             dcr_ack,
   // Register bus chain continuing into the fabric
   output logic             fab_dcr_read,
   output logic             fab_dcr_write,
   output logic [0:9]       fab_dcr_abus,
   output logic [0:31]      fab_dcr_wr_dbus,
   input  wire logic [0:31] fab_dcr_rd_dbus,
   input  wire logic        fab_dcr_ack,
   // Tie inputs
   input  wire logic [0:7]  data_ctrl_default,
   input  wire logic [0:7]  data_range_default,
   input  wire logic [0:7]  data_reg_base_tie,
   input  wire logic [0:7]  inst_ctrl_default,
   input  wire logic [0:7]  inst_range_default,
   input  wire logic [0:7]  inst_reg_base_tie,
   // Processor data side
   input  wire logic        cpu_ld_req,
   input  wire logic [0:31] cpu_ld_addr,
   output logic             cpu_ld_ack,
   output logic [0:31]      cpu_ld_data,
   output logic             cpu_ld_valid,
   input  wire logic        cpu_st_req,
   input  wire logic [0:31] cpu_st_addr,
   input  wire logic [0:31] cpu_st_data,
   input  wire logic [0:3]  cpu_st_be,
   output logic             cpu_st_ack,
   // Processor instruction side
   input  wire logic        cpu_if_req,
   input  wire logic [0:31] cpu_if_addr,
   output logic             cpu_if_ack,
   output logic [0:63]      cpu_if_data,
   output logic             cpu_if_valid,
   // Data memory port
   output logic [8:29]      data_addr_bus,
   output logic [0:31]      data_wr_bus,
   output logic [0:3]       data_byte_we,
   output logic             data_mem_en,
   input  wire logic [0:31] data_rd_bus,
   output logic             sw_flag_out,
   // Instruction memory port
   output logic [8:28]      inst_rd_addr,
   output logic             inst_rd_en,
   input  wire logic [0:63] inst_rd_bus,
   output logic [8:28]      inst_wr_addr,
   output logic [0:31]      inst_wr_bus,
   output logic             inst_even_we,
   output logic             inst_odd_we
);

   // ==========================================================
   // Data side, a separate controller with its own registers
   ombc_dcr_if dcr_d ();

   // Requests broadcast to the data side; it decodes its own base
   assign dcr_d.read  = dcr_read;
   assign dcr_d.write = dcr_write;
   assign dcr_d.abus  = dcr_abus;
   assign dcr_d.wdata = dcr_wr_dbus;

   // No shared bus or arbitration between the two sides
   ombc_data_side u_data_side (
      .sys_clk            (sys_clk),
      .rst_n              (rst_n),
      .dcr                (dcr_d.slave),
      .data_ctrl_default  (data_ctrl_default),
      .data_range_default (data_range_default),
      .data_reg_base_tie  (data_reg_base_tie),
      .cpu_ld_req         (cpu_ld_req),
      .cpu_ld_addr        (cpu_ld_addr),
      .cpu_ld_ack         (cpu_ld_ack),
      .cpu_ld_data        (cpu_ld_data),
      .cpu_ld_valid       (cpu_ld_valid),
      .cpu_st_req         (cpu_st_req),
      .cpu_st_addr        (cpu_st_addr),
      .cpu_st_data        (cpu_st_data),
      .cpu_st_be          (cpu_st_be),
      .cpu_st_ack         (cpu_st_ack),
      .data_addr_bus      (data_addr_bus),
      .data_wr_bus        (data_wr_bus),
      .data_byte_we       (data_byte_we),
      .data_mem_en        (data_mem_en),
      .data_rd_bus        (data_rd_bus),
      .sw_flag_out        (sw_flag_out)
   );

   // ==========================================================
   // Instruction-side registers
   logic        init_q;
   logic [0:7]  ictrl_q;
   logic [0:7]  irange_q;
   logic [0:20] wr_addr_q;
   logic [0:31] fill_q;
   logic        fill_pend_q;
   logic        iack_q;
   logic [0:31] irdata_q;
   logic        isel;
   logic        itake;
   logic [1:0]  iofs;
   logic        wr_addr_wr;
   logic        fill_wr;

   // Own base decode; a request is taken once, before its acknowledge
   assign isel  = ombc_pkg::dcr_sel(dcr_abus, inst_reg_base_tie);
   assign iofs  = ombc_pkg::dcr_ofs(dcr_abus);
   assign itake = (dcr_read || dcr_write) && isel && !iack_q;

   // Write strobes for the 21-bit write address and 32-bit fill registers
   assign wr_addr_wr = itake && dcr_write && iofs == ombc_pkg::OFS_INST_WR_ADDR;
   assign fill_wr    = itake && dcr_write && iofs == ombc_pkg::OFS_INST_FILL;

   // One-cycle flag that loads the tie defaults after reset release
   // Ties may settle while reset is low, so they are taken after it
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         init_q <= 1'b1;
      else
         init_q <= 1'b0;

   // Control and range compare registers
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         ictrl_q  <= ombc_pkg::CTRL_RESET;
         irange_q <= ombc_pkg::RANGE_RESET;
      end
      else if (init_q)
      begin
         ictrl_q  <= inst_ctrl_default;
         irange_q <= inst_range_default;
      end
      else if (itake && dcr_write)
      begin
         if (iofs == ombc_pkg::OFS_CTRL)
            ictrl_q <= dcr_wr_dbus[24:31];
         if (iofs == ombc_pkg::OFS_RANGE)
            irange_q <= dcr_wr_dbus[24:31];
      end

   // Write address: loaded by software, stepped once after each fill write
   // A software load wins over a step still pending
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         wr_addr_q <= ombc_pkg::WR_ADDR_RESET;
      else if (wr_addr_wr)
         wr_addr_q <= dcr_wr_dbus[0:20];
      else if (fill_pend_q)
         wr_addr_q <= wr_addr_q + ombc_pkg::WR_ADDR_STEP;

   // Fill data register and the pending write it triggers
   // The pending flag is the one-cycle write strobe
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         fill_q      <= ombc_pkg::FILL_RESET;
         fill_pend_q <= 1'b0;
      end
      else
      begin
         fill_pend_q <= fill_wr;
         if (fill_wr)
            fill_q <= dcr_wr_dbus;
      end

   // Acknowledge and read data for the instruction registers
   // Unused low bits of the write address read as zero
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         iack_q   <= 1'b0;
         irdata_q <= 32'h00000000;
      end
      else
      begin
         iack_q <= (dcr_read || dcr_write) && isel;
         if (itake)
            case (iofs)
               ombc_pkg::OFS_INST_WR_ADDR: irdata_q <= {wr_addr_q, 11'h000};
               ombc_pkg::OFS_INST_FILL:    irdata_q <= fill_q;
               ombc_pkg::OFS_RANGE:        irdata_q <= {24'h000000, irange_q};
               ombc_pkg::OFS_CTRL:         irdata_q <= {24'h000000, ictrl_q};
               default:                    irdata_q <= 32'h00000000;
            endcase
      end

   // ==========================================================
   // Instruction memory write port, fed from the registers
   // Address and data hold between fills; only the enables pulse
   assign inst_wr_addr = wr_addr_q;
   assign inst_wr_bus  = fill_q;
   // Only one half written per fill, picked by the word address lsb
   assign inst_even_we = fill_pend_q && !wr_addr_q[20];
   assign inst_odd_we  = fill_pend_q && wr_addr_q[20];

   // ==========================================================
   // Register bus loop, multiplexed with the fabric chain
   logic own_sel;

   // Requests to addresses owned by either side never reach the fabric chain
   assign own_sel         = isel || dcr_d.sel;
   assign fab_dcr_read    = dcr_read && !own_sel;
   assign fab_dcr_write   = dcr_write && !own_sel;
   assign fab_dcr_abus    = dcr_abus;
   assign fab_dcr_wr_dbus = dcr_wr_dbus;

   // Own answers are registered, the fabric's passes through
   assign dcr_ack         = dcr_d.ack || iack_q || (fab_dcr_ack && !own_sel);

   // Answer taken from whichever loop owns the address
   always_comb
   begin
      if (dcr_d.ack)
         dcr_rd_dbus = dcr_d.rdata;
      else if (iack_q)
         dcr_rd_dbus = irdata_q;
      else
         dcr_rd_dbus = fab_dcr_rd_dbus;
   end

   // ==========================================================
   // Instruction fetch path
   // Stages matching the fixed load latency of the data side
   logic if_p1_q;
   logic if_p2_q;

   // Fetch accepted only inside this side's own region
   assign cpu_if_ack = cpu_if_req &&
                       ombc_pkg::region_hit(cpu_if_addr[0:7], irange_q, ictrl_q);

   // Read address and enable launched from flops
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         inst_rd_addr <= 21'h000000;
         inst_rd_en   <= 1'b0;
      end
      else
      begin
         inst_rd_en <= cpu_if_ack;
         if (cpu_if_ack)
            inst_rd_addr <= cpu_if_addr[8:28];
      end

   // Two instructions returned together, two cycles after the enable
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         if_p1_q      <= 1'b0;
         if_p2_q      <= 1'b0;
         cpu_if_valid <= 1'b0;
         cpu_if_data  <= 64'h0000000000000000;
      end
      else
      begin
         if_p1_q      <= cpu_if_ack;
         if_p2_q      <= if_p1_q;
         cpu_if_valid <= if_p2_q;
         if (if_p2_q)
            cpu_if_data <= inst_rd_bus;
      end

endmodule

// ### tb/ombc_onchip_mem_ctrl_assertions.sv
// Port checker for the on-chip memory controller top.
// Assumes it is bound to ombc_onchip_mem_ctrl; single clock sys_clk.
`timescale 1ns/10ps
module ombc_chk (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        dcr_write,
   input wire logic [0:9]  dcr_abus,
   input wire logic [0:31] dcr_wr_dbus,
   input wire logic        dcr_ack,
   input wire logic [0:7]  data_reg_base_tie,
   input wire logic [0:7]  inst_reg_base_tie,
   input wire logic [0:31] cpu_ld_addr,
   input wire logic        cpu_ld_ack,
   input wire logic        cpu_st_ack,
   input wire logic [0:3]  cpu_st_be,
   input wire logic [0:31] cpu_st_data,
   input wire logic [0:31] cpu_if_addr,
   input wire logic        cpu_if_ack,
   input wire logic        data_mem_en,
   input wire logic [8:29] data_addr_bus,
   input wire logic [0:3]  data_byte_we,
   input wire logic [0:31] data_wr_bus,
   input wire logic        sw_flag_out,
   input wire logic [8:28] inst_wr_addr,
   input wire logic [0:31] inst_wr_bus,
   input wire logic        inst_even_we,
   input wire logic        inst_odd_we,
   input wire logic        inst_rd_en,
   input wire logic [8:28] inst_rd_addr
);
   // ==========================================================
   // Helper slices and clocking
   wire logic [8:29] ld_wa  = cpu_ld_addr[8:29];
   wire logic [8:28] if_wa  = cpu_if_addr[8:28];
   wire logic        flag_w = dcr_wr_dbus[26];
   wire logic        fill_w = dcr_write && !dcr_ack && dcr_abus == {inst_reg_base_tie, 2'h1};
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // ==========================================================
   // Assertions
   AST_LOAD_ACCESS:
      assert property (cpu_ld_ack |=> data_mem_en && data_byte_we == 4'h0 && data_addr_bus == $past(ld_wa))
      else $error("load access not launched");
   AST_STORE_ACCESS:
      assert property (cpu_st_ack |=> data_mem_en && data_byte_we == $past(cpu_st_be)
         && data_wr_bus == $past(cpu_st_data)) else $error("store access wrong");
   AST_LOAD_FIRST:
      assert property (cpu_ld_ack |-> !cpu_st_ack) else $error("store served beside load");
   AST_FLAG_MIRROR:
      assert property (dcr_write && dcr_ack && dcr_abus == {data_reg_base_tie, 2'h3}
         |=> sw_flag_out == $past(flag_w)) else $error("flag not mirrored");
   AST_FILL_STROBE:
      assert property (fill_w |=> (inst_even_we != inst_odd_we) && inst_odd_we == inst_wr_addr[28]
         && inst_wr_bus == $past(dcr_wr_dbus)) else $error("fill strobe wrong");
   AST_FILL_STEP:
      assert property (fill_w |=> ##1 inst_wr_addr == $past(inst_wr_addr) + 21'h000001)
      else $error("write address not stepped");
   AST_FETCH:
      assert property (cpu_if_ack |=> inst_rd_en && inst_rd_addr == $past(if_wa)) else $error("fetch wrong");
   AST_FETCH_ONLY:
      assert property (inst_rd_en |-> $past(cpu_if_ack)) else $error("read enable without fetch");
endmodule

bind ombc_onchip_mem_ctrl ombc_chk u_ombc_chk (.*);

// ### tb/ombc_bram_model.sv
// Block RAM model for the data and instruction memory ports.
// Assumes memory clocks equal sys_clk; outputs do not hold when idle.
`timescale 1ns/10ps
module ombc_bram_model (
   input wire logic        sys_clk,
   input wire logic [8:29] data_addr_bus,
   input wire logic [0:31] data_wr_bus,
   input wire logic [0:3]  data_byte_we,
   input wire logic        data_mem_en,
   output logic [0:31]     data_rd_bus,
   input wire logic [8:28] inst_rd_addr,
   input wire logic        inst_rd_en,
   output logic [0:63]     inst_rd_bus,
   input wire logic [8:28] inst_wr_addr,
   input wire logic [0:31] inst_wr_bus,
   input wire logic        inst_even_we,
   input wire logic        inst_odd_we
);
   // ==========================================================
   // Data memory: read-first, one write strobe per byte lane
   logic [0:31] mem [0:15];
   always_ff @(posedge sys_clk)
   begin
      if (data_mem_en)
      begin
         data_rd_bus <= mem[data_addr_bus[26:29]];
         for (int b = 0; b < 4; b++)
            if (data_byte_we[b])
               mem[data_addr_bus[26:29]][8*b +: 8] <= data_wr_bus[8*b +: 8];
      end
      else
         data_rd_bus <= ~data_rd_bus;
   end

   // Instruction memory: even word in [0:31], odd word in [32:63]
   logic [0:63] imem [0:3];
   always_ff @(posedge sys_clk)
   begin
      if (inst_rd_en)
         inst_rd_bus <= imem[inst_rd_addr[27:28]];
      else
         inst_rd_bus <= ~inst_rd_bus;
      // Both halves take the shared write data
      if (inst_even_we)
         imem[inst_wr_addr[26:27]][0:31] <= inst_wr_bus;
      if (inst_odd_we)
         imem[inst_wr_addr[26:27]][32:63] <= inst_wr_bus;
   end
endmodule

// ### tb/test_ombc_onchip_mem_ctrl.sv
// Bench for the on-chip memory controller: register bus, load, store, fetch.
// Assumes the controller top and the block RAM model on one 100 MHz clock.
`timescale 1ns/10ps
module test_ombc_onchip_mem_ctrl;
   // ==========================================================
   // Signals
   logic sys_clk, rst_n, dcr_read, dcr_write, dcr_ack, fab_dcr_read, fab_dcr_write, fab_dcr_ack;
   logic cpu_ld_req, cpu_ld_ack, cpu_ld_valid, cpu_st_req, cpu_st_ack, cpu_if_req, cpu_if_ack;
   logic cpu_if_valid, data_mem_en, sw_flag_out, inst_rd_en, inst_even_we, inst_odd_we;
   logic [0:9]  dcr_abus, fab_dcr_abus;
   logic [0:31] dcr_wr_dbus, dcr_rd_dbus, fab_dcr_wr_dbus, fab_dcr_rd_dbus, cpu_ld_addr, cpu_ld_data;
   logic [0:31] cpu_st_addr, cpu_st_data, cpu_if_addr, data_wr_bus, data_rd_bus, inst_wr_bus, rd, ldd;
   logic [0:63] cpu_if_data, inst_rd_bus, ifd;
   logic [0:7]  data_ctrl_default, data_range_default, data_reg_base_tie;
   logic [0:7]  inst_ctrl_default, inst_range_default, inst_reg_base_tie;
   logic [0:3]  cpu_st_be, data_byte_we;
   logic [8:29] data_addr_bus;
   logic [8:28] inst_rd_addr, inst_wr_addr;
   logic [0:2]  ak;
   int          err_total, samples_checked;

   ombc_onchip_mem_ctrl u_ombc_onchip_mem_ctrl (.*);
   ombc_bram_model u_ombc_bram_model (.*);

   // ==========================================================
   // Clock, fabric chain responder, returned data capture
   initial
   begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) fab_dcr_ack <= #1 fab_dcr_read | fab_dcr_write;
   assign fab_dcr_rd_dbus = {fab_dcr_abus, 22'h000ABC};
   always @(posedge sys_clk)
   begin
      if (cpu_ld_valid === 1'b1)
         ldd <= cpu_ld_data;
      if (cpu_if_valid === 1'b1)
         ifd <= cpu_if_data;
   end

   // ==========================================================
   // Tasks
   task automatic chk(input string n, input logic [0:63] e, input logic [0:63] g);
      samples_checked++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   // Register bus cycle: hold until acknowledged, then one idle gap
   task automatic dcr(input logic w, input logic [0:9] a, input logic [0:31] d);
      int n;
      @(posedge sys_clk) #1;
      {dcr_read, dcr_write, dcr_abus, dcr_wr_dbus} = {!w, w, a, d};
      n = 0;
      do
         @(posedge sys_clk) n++;
      while (dcr_ack !== 1'b1 && n < 20);
      rd = dcr_rd_dbus;
      if (n == 20)
         chk("dcr_ack", 1, dcr_ack);
      #1 {dcr_read, dcr_write} = 2'h0;
      repeat (2) @(posedge sys_clk);
   endtask

   // One-cycle load/store request with a fetch beside every load
   task automatic cpu(input logic ld, input logic st, input logic [0:31] a, input logic [0:31] d,
                      input logic [0:3] be);
      @(posedge sys_clk) #1;
      {ldd, ifd} = '0;
      {cpu_ld_req, cpu_st_req, cpu_if_req} = {ld, st, ld};
      {cpu_ld_addr, cpu_st_addr, cpu_if_addr} = {a, a, 8'h34, a[8:31]};
      {cpu_st_data, cpu_st_be} = {d, be};
      #1 ak = {cpu_ld_ack, cpu_st_ack, cpu_if_ack};
      @(posedge sys_clk) #1;
      {cpu_ld_req, cpu_st_req, cpu_if_req} = 3'h0;
      repeat (4) @(posedge sys_clk);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial
   begin
      {rst_n, dcr_read, dcr_write, cpu_ld_req, cpu_st_req, cpu_if_req, fab_dcr_ack} = 7'h00;
      {dcr_abus, dcr_wr_dbus, cpu_ld_addr, cpu_st_addr, cpu_st_data, cpu_if_addr, cpu_st_be} = '0;
      {data_ctrl_default, data_range_default, data_reg_base_tie} = 24'hA01207;
      {inst_ctrl_default, inst_range_default, inst_reg_base_tie} = 24'h80340B;
      repeat (12) @(posedge sys_clk);
      #1 rst_n = 1;
      repeat (3) @(posedge sys_clk);
      chk("flag", 1, sw_flag_out);
      dcr(0, 10'h01E, 0);
      chk("drange", 32'h12, rd);
      dcr(0, 10'h02F, 0);
      chk("ictrl", 32'h80, rd);
      dcr(0, 10'h01C, 0);
      chk("unmapped", 0, rd);
      dcr(0, 10'h3C5, 0);
      chk("fabric", {10'h3C5, 22'h000ABC}, rd);
      dcr(1, 10'h01F, 32'h80);
      chk("flag", 0, sw_flag_out);
      // Fill two instruction words starting at an even address
      dcr(1, 10'h02C, 32'h00001000);
      chk("waddr", 21'h2, inst_wr_addr);
      dcr(1, 10'h02D, 32'hCAFE0001);
      dcr(1, 10'h02D, 32'hCAFE0002);
      chk("waddr", 21'h4, inst_wr_addr);
      chk("wdata", 32'hCAFE0002, inst_wr_bus);
      dcr(0, 10'h02C, 0);
      chk("rdaddr", 32'h00002000, rd);
      // Word store, byte store, contended store, out of region load
      cpu(0, 1, 32'h12000008, 32'h11223344, 4'hF);
      chk("ack", 3'h2, ak);
      cpu(0, 1, 32'h12000008, 32'hAABBCCDD, 4'h4);
      cpu(1, 1, 32'h12000008, 32'h55555555, 4'hF);
      chk("ack", 3'h5, ak);
      chk("load", 32'h11BB3344, ldd);
      chk("fetch", {32'hCAFE0001, 32'hCAFE0002}, ifd);
      cpu(1, 0, 32'h13000010, 0, 4'h0);
      chk("ack", 3'h1, ak);
      chk("load", 0, ldd);
      end_sim;
   end

   initial
   begin
      #50000;
      err_total++;
      end_sim;
   end
endmodule
